/* rtl/frc_top.sv */
// Purpose: fault response controller with delayed response, retry and latch-off
// Assumes: fault_in and op_on come from logic on clk; ctrl_pin is asynchronous
// Notes: one fault source; the delay time unit is the UNIT_CYC parameter
//
// Behaviour
// - delayed mode: fault still present after delay applies the retry-field behaviour.
// - response 10 disables output at once, then restarts per retry field until an attempt reaches timer done with no fault or the retries run out.
// - response 11 keeps output off until the fault is cleared by any clear means.
// - restart attempt starts are spaced by delay field times the delay time unit.

`timescale 1ns/1ns

module frc_top #(
  parameter int UNIT_CYC = frc_pkg::UNIT_CYC_DEF
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // configuration and commands
  input wire logic [frc_pkg::RSP_W-1:0] rsp_byte,
  input wire logic clear_cmd,
  input wire logic status_clear,
  // enables
  input wire logic ctrl_pin,
  input wire logic op_on,
  // fault source
  input wire logic fault_in,
  // outputs
  output logic out_en,
  output logic fault_status,
  output logic [frc_pkg::RETRY_W-1:0] retries_left,
  output frc_pkg::frc_state_t state
);
  import frc_pkg::*;

  logic rst_s1_q;
  logic rst_n_q;
  logic ctrl_s1_q;
  logic ctrl_s2_q;
  logic out_en_q;
  logic fault_status_q;
  logic [RETRY_W-1:0] left_q;
  frc_state_t state_q;
  logic [1:0] resp;
  logic [RETRY_W-1:0] retry;
  logic [DLY_W-1:0] dly;
  logic enable;
  logic clear;
  logic start_d;
  logic shut_set;

  frc_tmr_if tif ();

  frc_timer #(
    .UNIT_CYC(UNIT_CYC)
  ) u_timer (
    .clk(clk),
    .rst_n(rst_n_q),
    .tif(tif)
  );

  // ----------------------------------------
  // reset release and pin synchroniser
  // ----------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ctrl_s1_q <= 1'b0;
      ctrl_s2_q <= 1'b0;
    end else begin
      ctrl_s1_q <= ctrl_pin;
      ctrl_s2_q <= ctrl_s1_q;
    end
  end

  // ----------------------------------------
  // field decode
  // ----------------------------------------
  assign resp = rsp_byte[RESP_MSB:RESP_LSB];
  assign retry = rsp_byte[RETRY_MSB:RETRY_LSB];
  assign dly = rsp_byte[DLY_MSB:DLY_LSB];
  assign enable = ctrl_s2_q & op_on;
  assign clear = clear_cmd | status_clear;
  assign tif.units = dly;
  assign tif.start = start_d;

  // timer restarts on a delay or retry fault in run, on delay expiry with retries set, and at every attempt start
  always_comb begin
    start_d = 1'b0;
    case (state_q)
      FRC_RUN: begin
        if (enable && fault_in && (resp == RESP_DELAY || resp == RESP_RETRY)) begin
          start_d = 1'b1;
        end
      end
      FRC_DELAY: begin
        if (enable && fault_in && tif.done && retry != RETRY_NONE) begin
          start_d = 1'b1;
        end
      end
      FRC_RETRY: begin
        if (enable && !clear && tif.done && !out_en_q && (left_q != '0 || retry == RETRY_ENDLESS)) begin
          start_d = 1'b1; // attempt spacing
        end
      end
      default: begin
        start_d = 1'b0;
      end
    endcase
  end

  // a shutdown that latches the status bit in this cycle
  always_comb begin
    shut_set = 1'b0;
    if (enable && fault_in) begin
      case (state_q)
        FRC_RUN: shut_set = (resp == RESP_RETRY) || (resp == RESP_LATCH);
        FRC_DELAY: shut_set = tif.done;
        FRC_RETRY: shut_set = out_en_q;
        default: shut_set = 1'b0;
      endcase
    end
  end

  // ----------------------------------------
  // response state machine
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q <= FRC_OFF;
      out_en_q <= 1'b0;
      left_q <= '0;
    end else if (!enable) begin
      state_q <= FRC_OFF; // off-then-on through pin or command clears
      out_en_q <= 1'b0;
      left_q <= '0;
    end else begin
      case (state_q)
        FRC_OFF: begin
          state_q <= FRC_RUN;
          out_en_q <= 1'b1;
        end
        FRC_RUN: begin
          if (fault_in) begin
            if (resp == RESP_DELAY) begin
              state_q <= FRC_DELAY;
            end else if (resp == RESP_RETRY) begin
              state_q <= FRC_RETRY; // disable at once
              out_en_q <= 1'b0;
              left_q <= retry;
            end else if (resp == RESP_LATCH) begin
              state_q <= FRC_LATCH; // off until cleared
              out_en_q <= 1'b0;
            end
          end
        end
        FRC_DELAY: begin
          if (!fault_in) begin
            state_q <= FRC_RUN;
          end else if (tif.done) begin
            out_en_q <= 1'b0; // expiry with fault applies retry field
            left_q <= retry;
            if (retry == RETRY_NONE) begin
              state_q <= FRC_LATCH;
            end else begin
              state_q <= FRC_RETRY;
            end
          end
        end
        FRC_RETRY: begin
          if (clear) begin
            state_q <= FRC_RUN;
            out_en_q <= 1'b1;
          end else if (out_en_q && fault_in) begin
            out_en_q <= 1'b0;
          end else if (tif.done) begin
            if (out_en_q) begin
              state_q <= FRC_RUN;
            end else if (retry == RETRY_ENDLESS) begin
              out_en_q <= 1'b1;
            end else if (left_q != '0) begin
              out_en_q <= 1'b1; // next attempt
              left_q <= left_q - 1'b1;
            end else begin
              state_q <= FRC_LATCH; // no attempts left, stay off
            end
          end
        end
        FRC_LATCH: begin
          if (clear) begin
            state_q <= FRC_RUN; // cleared by bit clear or command
            out_en_q <= 1'b1;
          end
        end
        default: begin
          state_q <= FRC_OFF;
          out_en_q <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // fault status bit
  // ----------------------------------------
  // set wins over clear so a fault in the clearing cycle is not lost
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      fault_status_q <= 1'b0;
    end else if (shut_set) begin
      fault_status_q <= 1'b1;
    end else if (clear || !enable) begin
      fault_status_q <= 1'b0;
    end
  end

  assign out_en = out_en_q;
  assign fault_status = fault_status_q;
  assign retries_left = left_q;
  assign state = state_q;

endmodule : frc_top

/* rtl/frc_pkg.sv */
// Purpose: shared constants and types for the fault response and retry controller
// Assumes: one 50 MHz clock, one fault source per instance
// Notes: response byte is split into response, retry and delay fields

package frc_pkg;

  // ----------------------------------------
  // clock and timing
  // ----------------------------------------
  localparam int CLK_MHZ = 50;
  localparam int DLY_UNIT_US = 1000;
  localparam int UNIT_CYC_DEF = DLY_UNIT_US * CLK_MHZ;
  // done register plus the consumer's edge, taken off the first unit
  localparam int TMR_HEAD = 2;

  // ----------------------------------------
  // response byte layout
  // ----------------------------------------
  localparam int RSP_W = 8;
  localparam int RESP_MSB = 7;
  localparam int RESP_LSB = 6;
  localparam int RETRY_MSB = 5;
  localparam int RETRY_LSB = 3;
  localparam int DLY_MSB = 2;
  localparam int DLY_LSB = 0;
  localparam int RETRY_W = RETRY_MSB - RETRY_LSB + 1;
  localparam int DLY_W = DLY_MSB - DLY_LSB + 1;
  localparam logic [RSP_W-1:0] RSP_RESET = 8'h00;

  // ----------------------------------------
  // field encodings
  // ----------------------------------------
  localparam logic [1:0] RESP_IGNORE = 2'h0;
  localparam logic [1:0] RESP_DELAY = 2'h1;
  localparam logic [1:0] RESP_RETRY = 2'h2;
  localparam logic [1:0] RESP_LATCH = 2'h3;
  localparam logic [RETRY_W-1:0] RETRY_NONE = 3'h0;
  localparam logic [RETRY_W-1:0] RETRY_ENDLESS = 3'h7;

  typedef enum logic [2:0] {
    FRC_OFF,
    FRC_RUN,
    FRC_DELAY,
    FRC_RETRY,
    FRC_LATCH
  } frc_state_t;

endpackage : frc_pkg

/* rtl/frc_tmr_if.sv */
// Purpose: start and done handshake between controller and interval timer
// Assumes: both ends on the same clock
// Notes: start and done are one-cycle pulses

`timescale 1ns/1ns

interface frc_tmr_if;
  logic start;
  logic [frc_pkg::DLY_W-1:0] units;
  logic done;

  modport ctl (output start, output units, input done);
  modport tmr (input start, input units, output done);
endinterface : frc_tmr_if

/* rtl/frc_timer.sv */
// Purpose: counts a number of delay time units
// Assumes: start restarts the count at once, even while busy
// Notes: zero units gives done two cycles after the start pulse; UNIT_CYC must exceed TMR_HEAD

`timescale 1ns/1ns

module frc_timer #(
  parameter int UNIT_CYC = frc_pkg::UNIT_CYC_DEF
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  frc_tmr_if.tmr tif
);
  import frc_pkg::*;

  localparam int PRE_W = (UNIT_CYC > 1) ? $clog2(UNIT_CYC) : 1;
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(UNIT_CYC - 1);

  logic busy_q;
  logic [DLY_W-1:0] units_q;
  logic [PRE_W-1:0] pre_q;
  logic done_q;

  assign tif.done = done_q;

  // ----------------------------------------
  // unit prescaler and unit count
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
      units_q <= '0;
      pre_q <= '0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (tif.start) begin
        busy_q <= 1'b1;
        units_q <= tif.units;
        // head start so the consumer acts exactly units times unit after start
        pre_q <= PRE_W'(TMR_HEAD);
      end else if (busy_q) begin
        if (units_q == '0) begin
          busy_q <= 1'b0;
          done_q <= 1'b1; // delay value times unit
        end else if (pre_q == PRE_LAST) begin
          pre_q <= '0;
          units_q <= units_q - 1'b1;
        end else begin
          pre_q <= pre_q + 1'b1;
        end
      end
    end
  end

endmodule : frc_timer

/* test/frc_top_monitor.sv */
// Purpose: assertion checker on frc_top ports
// Assumes: ctrl_pin held steady three samples counts as synced
// Notes: retry gap measured between attempt rises
`timescale 1ns/1ns
module frc_top_monitor #(
  parameter int UNIT_CYC = frc_pkg::UNIT_CYC_DEF
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // inputs
  input wire logic [frc_pkg::RSP_W-1:0] rsp_byte,
  input wire logic clear_cmd,
  input wire logic status_clear,
  input wire logic ctrl_pin,
  input wire logic op_on,
  input wire logic fault_in,
  // outputs
  input wire logic out_en,
  input wire logic fault_status,
  input wire logic [frc_pkg::RETRY_W-1:0] retries_left,
  input wire frc_pkg::frc_state_t state
);
  import frc_pkg::*;
  // ----
  // helpers
  // ----
  logic [2:0] pin_q;
  logic oe_q;
  logic seen_q;
  logic [15:0] gap_q;
  logic en;
  logic clr;
  logic att;
  assign en = op_on & ctrl_pin & (&pin_q);
  assign clr = clear_cmd | status_clear;
  assign att = out_en & ~oe_q & (state == FRC_RETRY);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pin_q <= 3'h0;
      oe_q <= 1'b0;
    end else begin
      pin_q <= {pin_q[1:0], ctrl_pin};
      oe_q <= out_en;
    end
  end
  // gap counter restarts at each attempt rise and counts only while in retry
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gap_q <= 16'h0000;
      seen_q <= 1'b0;
    end else if (att) begin
      gap_q <= 16'h0001;
      seen_q <= 1'b1;
    end else if (state != FRC_RETRY) begin
      seen_q <= 1'b0;
    end else begin
      gap_q <= gap_q + 16'h0001;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // ----
  // properties
  // ----
  property p_latch;
    state == FRC_RUN && fault_in && en && rsp_byte[7:6] == RESP_LATCH
      |=> state == FRC_LATCH && !out_en && fault_status;
  endproperty
  a_latch: assert property (p_latch) else $error("latch response wrong");
  property p_retry;
    state == FRC_RUN && fault_in && en && rsp_byte[7:6] == RESP_RETRY
      |=> state == FRC_RETRY && !out_en && fault_status && retries_left == $past(rsp_byte[5:3]);
  endproperty
  a_retry: assert property (p_retry) else $error("retry response wrong");
  property p_delay;
    state == FRC_RUN && fault_in && en && rsp_byte[7:6] == RESP_DELAY |=> state == FRC_DELAY && out_en;
  endproperty
  a_delay: assert property (p_delay) else $error("delay response wrong");
  property p_dly_end;
    $fell(out_en) && $past(state) == FRC_DELAY && $past(op_on) && (&pin_q)
      |-> fault_status && state == (rsp_byte[5:3] == RETRY_NONE ? FRC_LATCH : FRC_RETRY);
  endproperty
  a_dly_end: assert property (p_dly_end) else $error("delay expiry wrong");
  property p_hold;
    state == FRC_LATCH && !clr && en |=> state == FRC_LATCH && !out_en;
  endproperty
  a_hold: assert property (p_hold) else $error("latched output came back");
  property p_noretry;
    state == FRC_RETRY && rsp_byte[5:3] == RETRY_NONE && !clr && op_on |=> !out_en;
  endproperty
  a_noretry: assert property (p_noretry) else $error("restart with zero retries");
  property p_clear;
    (state == FRC_LATCH || state == FRC_RETRY) && clr && en && !fault_in
      |=> state == FRC_RUN && out_en && !fault_status;
  endproperty
  a_clear: assert property (p_clear) else $error("clear not taken");
  property p_off;
    !op_on |=> state == FRC_OFF && !out_en && !fault_status;
  endproperty
  a_off: assert property (p_off) else $error("disable not taken");
  property p_gap;
    att && seen_q |-> gap_q == rsp_byte[2:0] * UNIT_CYC;
  endproperty
  a_gap: assert property (p_gap) else $error("retry spacing wrong");
endmodule : frc_top_monitor

bind frc_top frc_top_monitor #(.UNIT_CYC(UNIT_CYC)) mon (.clk(clk), .nrst(nrst), .rsp_byte(rsp_byte),
  .clear_cmd(clear_cmd), .status_clear(status_clear), .ctrl_pin(ctrl_pin), .op_on(op_on), .fault_in(fault_in),
  .out_en(out_en), .fault_status(fault_status), .retries_left(retries_left), .state(state));

/* test/frc_host.sv */
// Purpose: host model for response byte, clears and enables
// Assumes: every change lands on a falling edge
// Notes: clears are one-cycle pulses, as a bus command would give
`timescale 1ns/1ns
module frc_host (
  // clock
  input wire logic clk,
  // to the block
  output logic [frc_pkg::RSP_W-1:0] rsp_byte,
  output logic clear_cmd,
  output logic status_clear,
  output logic ctrl_pin,
  output logic op_on
);
  import frc_pkg::*;
  initial begin
    rsp_byte = RSP_RESET;
    clear_cmd = 1'b0;
    status_clear = 1'b0;
    ctrl_pin = 1'b0;
    op_on = 1'b0;
  end
  task automatic set(input logic [7:0] b);
    @(negedge clk) rsp_byte = b;
  endtask : set
  // kind 0 is the clear command, 1 the status bit clear
  task automatic clr(input logic kind);
    @(negedge clk);
    clear_cmd = ~kind;
    status_clear = kind;
    @(negedge clk);
    clear_cmd = 1'b0;
    status_clear = 1'b0;
  endtask : clr
  task automatic pwr(input logic pin, input logic op);
    @(negedge clk);
    ctrl_pin = pin;
    op_on = op;
  endtask : pwr
endmodule : frc_host

/* test/frc_top_test.sv */
// Purpose: self-checking bench for frc_top
// Assumes: delay unit shortened to 4 cycles
// Notes: inputs move on falling edges
`timescale 1ns/1ns
module frc_top_test;
  import frc_pkg::*;
  localparam int U = 4;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic fault_in = 1'b0;
  logic [7:0] rsp_byte;
  logic clear_cmd, status_clear, ctrl_pin, op_on, out_en, fault_status;
  logic [2:0] retries_left;
  frc_state_t state;
  int fails = 0;
  int n_tests = 0;
  int cyc = 0;
  always #10 clk = ~clk;
  frc_host host (.clk(clk), .rsp_byte(rsp_byte), .clear_cmd(clear_cmd), .status_clear(status_clear),
    .ctrl_pin(ctrl_pin), .op_on(op_on));
  frc_top #(.UNIT_CYC(U)) dut (.clk(clk), .nrst(nrst), .rsp_byte(rsp_byte), .clear_cmd(clear_cmd),
    .status_clear(status_clear), .ctrl_pin(ctrl_pin), .op_on(op_on), .fault_in(fault_in), .out_en(out_en),
    .fault_status(fault_status), .retries_left(retries_left), .state(state));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  // fault taken at one edge; hold keeps it present
  task automatic hit(input logic [7:0] b, input logic hold);
    host.set(b);
    @(negedge clk) fault_in = 1'b1;
    tick(1);
    @(negedge clk) fault_in = hold;
  endtask : hit
  task automatic t_latch;
    hit(8'hC0, 1'b0);
    tick(8);
    chk({out_en, fault_status, state}, {1'b0, 1'b1, FRC_LATCH});
    host.clr(1'b0);
    chk({out_en, fault_status, state}, {1'b1, 1'b0, FRC_RUN});
    hit(8'hC0, 1'b0);
    host.clr(1'b1);
    chk({out_en, fault_status, state}, {1'b1, 1'b0, FRC_RUN});
    hit(8'hC0, 1'b0);
    host.pwr(1'b0, 1'b1);
    tick(5);
    chk({out_en, fault_status, state}, {1'b0, 1'b0, FRC_OFF});
    host.pwr(1'b1, 1'b1);
    tick(8);
    chk({out_en, fault_status, state}, {1'b1, 1'b0, FRC_RUN});
  endtask : t_latch
  task automatic t_retry;
    int rise[$];
    logic prev;
    int n;
    hit(8'h91, 1'b1);
    chk({fault_status, state, retries_left}, {1'b1, FRC_RETRY, 3'h2});
    prev = 1'b0;
    for (int i = 0; i < 30; i++) begin
      tick(1);
      if (out_en === 1'b1 && !prev) rise.push_back(i);
      prev = (out_en === 1'b1);
    end
    chk(8'(rise.size()), 8'h02);
    if (rise.size() == 2) begin
      chk(8'(rise[0]), 8'(U - 1));
      chk(8'(rise[1] - rise[0]), 8'(U));
    end
    chk({state, retries_left}, {FRC_LATCH, 3'h0});
    @(negedge clk) fault_in = 1'b0;
    host.clr(1'b0);
    hit(8'hB9, 1'b1);
    chk({state, retries_left}, {FRC_RETRY, 3'h7});
    n = 0;
    prev = 1'b0;
    for (int i = 0; i < 20; i++) begin
      tick(1);
      if (out_en === 1'b1 && !prev) n++;
      prev = (out_en === 1'b1);
    end
    chk(8'(n), 8'(20 / U));
    chk({state, retries_left}, {FRC_RETRY, 3'h7});
    @(negedge clk) fault_in = 1'b0;
    host.clr(1'b0);
    chk({out_en, fault_status, state}, {1'b1, 1'b0, FRC_RUN});
  endtask : t_retry
  task automatic t_delay;
    int n;
    hit(8'h42, 1'b1);
    chk({out_en, state}, {1'b1, FRC_DELAY});
    n = 0;
    while (out_en === 1'b1 && n < 40) begin
      tick(1);
      n++;
    end
    chk(8'(n), 8'(2 * U));
    chk({fault_status, state}, {1'b1, FRC_LATCH});
    @(negedge clk) fault_in = 1'b0;
    host.clr(1'b1);
    hit(8'h42, 1'b0);
    tick(12);
    chk({out_en, fault_status, state}, {1'b1, 1'b0, FRC_RUN});
    hit(8'h00, 1'b0);
    tick(4);
    chk({out_en, fault_status, state}, {1'b1, 1'b0, FRC_RUN});
  endtask : t_delay
  task automatic t_none;
    int n;
    hit(8'h81, 1'b0);
    chk({state, retries_left}, {FRC_RETRY, 3'h0});
    n = 0;
    repeat (12) begin
      tick(1);
      if (out_en !== 1'b0) n++;
    end
    chk(8'(n), 8'h00);
    chk(state, FRC_LATCH);
    host.pwr(1'b1, 1'b0);
    tick(2);
    chk({out_en, state}, {1'b0, FRC_OFF});
    host.pwr(1'b1, 1'b1);
    tick(3);
    chk({out_en, state}, {1'b1, FRC_RUN});
  endtask : t_none
  // reset input in mid-run clears a latched fault
  task automatic t_reset;
    hit(8'hC0, 1'b0);
    chk({out_en, fault_status, state}, {1'b0, 1'b1, FRC_LATCH});
    @(negedge clk) nrst = 1'b0;
    tick(1);
    chk({out_en, fault_status, state}, {1'b0, 1'b0, FRC_OFF});
    @(negedge clk) nrst = 1'b1;
    tick(8);
    chk({out_en, fault_status, state}, {1'b1, 1'b0, FRC_RUN});
  endtask : t_reset
  task automatic wrap_up;
    $display("tests=%0d fails=%0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up
  initial begin
    tick(2);
    @(negedge clk) nrst = 1'b1;
    host.pwr(1'b1, 1'b1);
    tick(8);
    chk({out_en, state}, {1'b1, FRC_RUN});
    t_latch;
    t_retry;
    t_delay;
    t_none;
    t_reset;
    wrap_up;
  end
  // run needs about 170 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      fails++;
      wrap_up;
    end
  end
endmodule : frc_top_test
